// ---- design/urx_rx_endpoint.sv ----
// Purpose: receive side of one full-speed endpoint: FIFO port, status and control.
// Assumes: serial engine delivers PID, payload and CRC16 bytes between sop and eop.
// Notes: register reads answer two cycles after the strobe; writes take effect next edge.
`timescale 1ns/1ps
module urx_rx_endpoint
  import urx_pkg::*;
(
  input  wire logic         SYS_CLK,
  input  wire logic         NRST,
  input  wire urx_reg_req_t REG_REQ,
  output logic [15:0]       REG_RDATA,
  output logic              REG_ACK,
  input  wire urx_link_t    LINK,
  input  wire logic         EP_ISO,
  input  wire logic         EP_STALL,
  input  wire logic         FRAME_LSB,
  input  wire logic         TEST_MODE,
  output logic              HS_ACK,
  output logic              HS_NAK,
  output logic              HS_STALL,
  output logic              RX_WARN_FLAG
);
  urx_state_t  st, next_st;
  logic        ctl_en, ctl_ign, ctl_flush;
  logic [1:0]  ctl_wl;
  logic        next_ctl_en, next_ctl_ign, next_ctl_flush;
  logic [1:0]  next_ctl_wl;
  logic        s_err, s_setup, s_tog, s_ack;
  logic        next_s_err, next_s_setup, next_s_tog, next_s_ack;
  logic        is_setup, pid_tog, ovr;
  logic        next_is_setup, next_pid_tog, next_ovr;
  logic [7:0]  h0, h1, next_h0, next_h1;
  logic [1:0]  hc, next_hc;
  logic        hs_ack, hs_nak, hs_stall, warn;
  logic        next_hs_ack, next_hs_nak, next_hs_stall, next_warn;
  logic        rv1, rpop, rack;
  logic [1:0]  rsel;
  logic [15:0] rsnap, rdata;
  logic        next_rv1, next_rpop, next_rack;
  logic [1:0]  next_rsel;
  logic [15:0] next_rsnap, next_rdata;

  logic        hit_d, hit_s, hit_c, rd_any, rd_d, rd_s, wr_c, wr_d;
  logic        push_v, pop, flush_go, done_ok, fin_rdy, fout_v;
  logic [7:0]  push_d, fout_d;
  logic [5:0]  fcnt, free, lim;
  logic [3:0]  cnt_sat;
  logic [15:0] stat_view, ctrl_view;

  assign REG_RDATA    = rdata;
  assign REG_ACK      = rack;
  assign HS_ACK       = hs_ack;
  assign HS_NAK       = hs_nak;
  assign HS_STALL     = hs_stall;
  assign RX_WARN_FLAG = warn;

  urx_fifo #(
    .W (FIFO_WIDTH),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clk       (SYS_CLK),
    .rst_n     (NRST),
    .flush     (flush_go),
    .in_valid  (push_v),
    .in_ready  (fin_rdy),
    .in_data   (push_d),
    .out_valid (fout_v),
    .out_ready (pop),
    .out_data  (fout_d),
    .count     (fcnt)
  );

  always_comb begin
    hit_d    = (REG_REQ.addr == RXD_ADDR);
    hit_s    = (REG_REQ.addr == RXS_ADDR);
    hit_c    = (REG_REQ.addr == RXC_ADDR);
    rd_any   = REG_REQ.rd && !REG_REQ.wr;
    rd_d     = rd_any && hit_d;
    rd_s     = rd_any && hit_s;
    wr_c     = REG_REQ.wr && hit_c;
    wr_d     = REG_REQ.wr && hit_d && TEST_MODE;
    pop      = rd_d && fout_v;
    flush_go = ctl_flush && (st == S_IDLE);
    cnt_sat  = (fcnt > CNT_MAX) ? CNT_SAT : fcnt[3:0];
    free     = FIFO_FULL - fcnt;
    unique case (ctl_wl)
      2'h1:    lim = WARN_LIM1;
      2'h2:    lim = WARN_LIM2;
      2'h3:    lim = WARN_LIM3;
      default: lim = 6'h00;
    endcase
    stat_view = {8'h00, s_err, s_setup, s_tog, s_ack, cnt_sat};
    ctrl_view = {9'h000, ctl_wl, 1'b0, ctl_flush, ctl_ign, 1'b0, ctl_en};
  end

  always_comb begin
    next_st        = st;
    next_ctl_en    = ctl_en;
    next_ctl_ign   = ctl_ign;
    next_ctl_flush = ctl_flush;
    next_ctl_wl    = ctl_wl;
    next_s_err     = s_err;
    next_s_setup   = s_setup;
    next_s_tog     = s_tog;
    next_s_ack     = s_ack;
    next_is_setup  = is_setup;
    next_pid_tog   = pid_tog;
    next_ovr       = ovr;
    next_h0        = h0;
    next_h1        = h1;
    next_hc        = hc;
    next_hs_ack    = 1'b0;
    next_hs_nak    = 1'b0;
    next_hs_stall  = 1'b0;
    done_ok        = 1'b0;
    push_v         = wr_d;
    push_d         = REG_REQ.wdata[7:0];
    // Read clears come first so a same-cycle hardware set wins
    if (rd_s) begin
      next_s_setup = 1'b0;
      next_s_tog   = 1'b0;
      next_s_ack   = 1'b0;
    end
    if (flush_go) begin
      next_ctl_flush = 1'b0;
      next_hc        = 2'h0;
      next_s_err     = 1'b0;
    end
    unique case (st)
      S_IDLE: begin
        if (LINK.sop) begin
          if (LINK.setup) begin
            if (!ctl_ign) begin
              next_st       = S_PID;
              next_is_setup = 1'b1;
              next_ovr      = 1'b0;
              next_hc       = 2'h0;
            end
          end else if (EP_STALL) begin
            next_hs_stall = 1'b1;
            next_ctl_en   = 1'b0;
          end else if (ctl_en) begin
            next_st       = S_PID;
            next_is_setup = 1'b0;
            next_ovr      = 1'b0;
            next_hc       = 2'h0;
          end else if (!EP_ISO) begin
            next_hs_nak = 1'b1;
          end
        end
      end
      S_PID: begin
        if (LINK.err) begin
          next_s_err = 1'b1;
          next_st    = S_IDLE;
        end else if (LINK.vld) begin
          // PID byte is consumed here and never pushed
          next_pid_tog = (LINK.data == PID_DATA1);
          next_st      = S_DATA;
        end else if (LINK.eop) begin
          next_st = S_IDLE;
        end
      end
      S_DATA: begin
        if (LINK.err) begin
          next_s_err = 1'b1;
          next_st    = S_IDLE;
          next_hc    = 2'h0;
        end else begin
          if (LINK.vld) begin
            // Two bytes stay held back so the CRC16 can be dropped at eop
            if (hc == CRC_BYTES) begin
              push_v = 1'b1;
              push_d = h1;
              if (!fin_rdy) begin
                next_ovr = 1'b1;
              end
            end else begin
              next_hc = hc + 2'h1;
            end
            next_h1 = h0;
            next_h0 = LINK.data;
          end
          if (LINK.eop) begin
            next_st     = S_IDLE;
            next_hc     = 2'h0;
            next_ctl_en = 1'b0;
            if (next_ovr) begin
              next_hs_nak = !EP_ISO;
            end else begin
              done_ok    = 1'b1;
              next_s_tog = EP_ISO ? FRAME_LSB : pid_tog;
              if (!EP_ISO) begin
                next_hs_ack = 1'b1;
                next_s_ack  = 1'b1;
              end
              if (is_setup) begin
                next_s_setup = 1'b1;
              end
            end
          end
        end
      end
      default: next_st = S_IDLE;
    endcase
    // Software write lands after the hardware clear, so a re-enable is never lost
    if (wr_c) begin
      next_ctl_en  = REG_REQ.wdata[CT_EN];
      next_ctl_ign = REG_REQ.wdata[CT_IGN];
      next_ctl_wl  = REG_REQ.wdata[CT_WL_HI:CT_WL_LO];
      if (REG_REQ.wdata[CT_FLUSH]) begin
        next_ctl_flush = 1'b1;
      end
    end
    next_warn = (ctl_wl != 2'h0) && (free <= lim);
  end

  always_comb begin
    next_rv1   = rd_any;
    next_rpop  = pop;
    next_rsnap = hit_s ? stat_view : ctrl_view;
    if (hit_d) begin
      next_rsel = SEL_DATA;
    end else if (hit_s) begin
      next_rsel = SEL_STAT;
    end else if (hit_c) begin
      next_rsel = SEL_CTRL;
    end else begin
      next_rsel = SEL_NONE;
    end
    next_rack = rv1;
    unique case (rsel)
      SEL_DATA: next_rdata = {8'h00, rpop ? fout_d : 8'h00};
      SEL_STAT: next_rdata = rsnap;
      SEL_CTRL: next_rdata = rsnap;
      default:  next_rdata = 16'h0000;
    endcase
    if (!rv1) begin
      next_rdata = 16'h0000;
    end
  end

  always_ff @(posedge SYS_CLK or negedge NRST) begin
    if (!NRST) begin
      st        <= S_IDLE;
      ctl_en    <= REG_RST[CT_EN];
      ctl_ign   <= REG_RST[CT_IGN];
      ctl_flush <= REG_RST[CT_FLUSH];
      ctl_wl    <= REG_RST[CT_WL_HI:CT_WL_LO];
      s_err     <= REG_RST[ST_ERR];
      s_setup   <= REG_RST[ST_SETUP];
      s_tog     <= REG_RST[ST_TOG];
      s_ack     <= REG_RST[ST_ACK];
      is_setup  <= 1'b0;
      pid_tog   <= 1'b0;
      ovr       <= 1'b0;
      h0        <= 8'h00;
      h1        <= 8'h00;
      hc        <= 2'h0;
      hs_ack    <= 1'b0;
      hs_nak    <= 1'b0;
      hs_stall  <= 1'b0;
      warn      <= 1'b0;
      rv1       <= 1'b0;
      rpop      <= 1'b0;
      rsel      <= SEL_NONE;
      rsnap     <= REG_RST;
      rdata     <= REG_RST;
      rack      <= 1'b0;
    end else begin
      st        <= next_st;
      ctl_en    <= next_ctl_en;
      ctl_ign   <= next_ctl_ign;
      ctl_flush <= next_ctl_flush;
      ctl_wl    <= next_ctl_wl;
      s_err     <= next_s_err;
      s_setup   <= next_s_setup;
      s_tog     <= next_s_tog;
      s_ack     <= next_s_ack;
      is_setup  <= next_is_setup;
      pid_tog   <= next_pid_tog;
      ovr       <= next_ovr;
      h0        <= next_h0;
      h1        <= next_h1;
      hc        <= next_hc;
      hs_ack    <= next_hs_ack;
      hs_nak    <= next_hs_nak;
      hs_stall  <= next_hs_stall;
      warn      <= next_warn;
      rv1       <= next_rv1;
      rpop      <= next_rpop;
      rsel      <= next_rsel;
      rsnap     <= next_rsnap;
      rdata     <= next_rdata;
      rack      <= next_rack;
    end
  end

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);

  pid_strip_a: assert property ((st == S_PID) && !wr_d |-> !push_v)
    else $error("PID byte reached the FIFO");
  test_wr_a: assert property (wr_d && fin_rdy && !pop && !flush_go && (st == S_IDLE)
      |=> fcnt == $past(fcnt) + 6'h01)
    else $error("test write did not push");
  err_set_a: assert property ((st != S_IDLE) && LINK.err |=> s_err && (st == S_IDLE))
    else $error("media error not flagged");
  stat_clr_a: assert property (rd_s && !done_ok |=> !s_setup && !s_tog && !s_ack)
    else $error("status read did not clear flags");
  setup_set_a: assert property (done_ok && is_setup |=> s_setup)
    else $error("setup flag not set");
  tog_src_a: assert property (done_ok && !EP_ISO |=> s_tog == $past(pid_tog))
    else $error("toggle bit wrong");
  frame_bit_a: assert property (done_ok && EP_ISO |=> s_tog == $past(FRAME_LSB))
    else $error("frame bit not captured");
  ack_flag_a: assert property (HS_ACK |-> s_ack && $past(done_ok))
    else $error("ack without status flag");
  count_sat_a: assert property (rd_s && (fcnt > CNT_MAX) |-> ##2 REG_ACK &&
      REG_RDATA[3:0] == CNT_SAT)
    else $error("count not saturated");
  warn_lvl_a: assert property ((ctl_wl == 2'h1) && (free < 6'h05) |=> RX_WARN_FLAG)
    else $error("warning limit not applied");
  warn_off_a: assert property ((ctl_wl == 2'h0) |=> !RX_WARN_FLAG)
    else $error("warning raised while disabled");
  iso_nak_a: assert property (HS_NAK |-> !$past(EP_ISO))
    else $error("NAK on isochronous endpoint");
  en_clr_a: assert property ((done_ok || next_hs_stall) && !wr_c |=> !ctl_en)
    else $error("receive enable not cleared");
  flush_wait_a: assert property (ctl_flush && (st != S_IDLE) |=> ctl_flush)
    else $error("flush during reception");
  flush_clr_a: assert property (flush_go && !wr_c |=> fcnt == 6'h00 && !ctl_flush)
    else $error("flush did not empty FIFO");
  pop_cnt_a: assert property (pop && !push_v && !flush_go |=> fcnt == $past(fcnt) - 6'h01)
    else $error("read did not remove a byte");
endmodule

// ---- include/urx_pkg.sv ----
// Purpose: shared constants and types for the receive endpoint block.
// Assumes: 16-bit core register port, 8-bit payload bytes from the serial engine.
// Notes:
// Functional notes
// - The data port gives only payload bytes in bits 7:0; PID and CRC16 never reach the FIFO.
// - In test mode the data port can also be written from the core bus, pushing a byte.
// - Status bit 7 is set on a receive media error such as bit stuffing or CRC.
// - Status bit 6 is set when a good SETUP packet is received and clears when status is read.
// - On a non-isochronous endpoint status bit 5 is the DATA0/DATA1 toggle of the last good packet.
// - On an isochronous endpoint status bit 5 takes the frame number LSB after each good packet.
// - Reading the status register clears the toggle/frame bit to zero.
// - Status bit 4 is set when an ACK was returned for a good packet and clears on status read.
// - The 4-bit count field shows the bytes held in the FIFO, saturating at 15.
// - The 2-bit warning limit selects off, or fewer than 5, 9 or 17 free bytes.
// - The warning flag is raised while the free bytes are at or below the selected limit.
// - An isochronous endpoint never answers NAK.
// - Reception is disabled after each data packet not aborted by a media error, or a STALL to OUT; software re-enables it.
// - A flush empties the FIFO and clears the error bit, waiting for a reception in progress.
package urx_pkg;
  localparam logic [31:0] RXD_ADDR     = 32'h5000185A;
  localparam logic [31:0] RXS_ADDR     = 32'h5000185C;
  localparam logic [31:0] RXC_ADDR     = 32'h5000185E;
  localparam logic [15:0] REG_RST      = 16'h0000;
  localparam int          ST_ERR       = 7;
  localparam int          ST_SETUP     = 6;
  localparam int          ST_TOG       = 5;
  localparam int          ST_ACK       = 4;
  localparam int          CT_EN        = 0;
  localparam int          CT_IGN       = 2;
  localparam int          CT_FLUSH     = 3;
  localparam int          CT_WL_LO     = 5;
  localparam int          CT_WL_HI     = 6;
  localparam int          FIFO_WIDTH   = 8;
  localparam int          FIFO_DEPTH   = 32;
  localparam logic [5:0]  FIFO_FULL    = 6'h20;
  localparam logic [5:0]  CNT_MAX      = 6'h0F;
  localparam logic [3:0]  CNT_SAT      = 4'hF;
  localparam logic [5:0]  WARN_LIM1    = 6'h04;
  localparam logic [5:0]  WARN_LIM2    = 6'h08;
  localparam logic [5:0]  WARN_LIM3    = 6'h10;
  localparam logic [7:0]  PID_DATA1    = 8'h4B;
  localparam logic [1:0]  CRC_BYTES    = 2'h2;
  localparam logic [1:0]  SEL_DATA     = 2'h0;
  localparam logic [1:0]  SEL_STAT     = 2'h1;
  localparam logic [1:0]  SEL_CTRL     = 2'h2;
  localparam logic [1:0]  SEL_NONE     = 2'h3;

  typedef enum logic [1:0] {S_IDLE, S_PID, S_DATA} urx_state_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } urx_reg_req_t;

  typedef struct packed {
    logic       sop;
    logic       setup;
    logic       vld;
    logic [7:0] data;
    logic       eop;
    logic       err;
  } urx_link_t;
endpackage

// ---- design/urx_fifo.sv ----
// Purpose: byte FIFO with registered read data between packet engine and core bus.
// Assumes: one clock; flush clears both pointers at once.
// Notes: out_data is loaded on the pop edge, so data follows the pop by one cycle.
`timescale 1ns/1ps
module urx_fifo #(
  parameter int W  = 8,
  parameter int D  = 32,
  parameter int AW = $clog2(D)
) (
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic          flush,
  input  wire logic          in_valid,
  output logic               in_ready,
  input  wire logic [W-1:0]  in_data,
  output logic               out_valid,
  input  wire logic          out_ready,
  output logic [W-1:0]       out_data,
  output logic [AW:0]        count
);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0]   next_count;
  logic          do_push, do_pop;

  assign in_ready  = (count < (AW+1)'(D));
  assign out_valid = (count != '0);

  always_comb begin
    do_push    = in_valid && in_ready && !flush;
    do_pop     = out_ready && out_valid && !flush;
    next_wp    = do_push ? wp + 1'b1 : wp;
    next_rp    = do_pop ? rp + 1'b1 : rp;
    next_count = count + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (flush) begin
      next_wp    = '0;
      next_rp    = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp       <= '0;
      rp       <= '0;
      count    <= '0;
      out_data <= '0;
    end else begin
      wp    <= next_wp;
      rp    <= next_rp;
      count <= next_count;
      if (do_pop) begin
        out_data <= mem[rp];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wp] <= in_data;
    end
  end
endmodule

// ---- tb/urx_host_model.sv ----
// Purpose: host and serial engine side: sends token, PID, payload and CRC bytes.
// Assumes: link signals change just after the rising edge.
// Notes: idle data lines carry the inverse of the last byte, so no stale byte can pass.
`timescale 1ns/1ps
module urx_host_model
  import urx_pkg::*;
(
  input  wire logic clk,
  output urx_link_t link,
  input  wire logic hs_ack,
  input  wire logic hs_nak,
  input  wire logic hs_stall
);
  logic [2:0] hs_acc;

  initial link = '0;
  initial hs_acc = 3'h0;

  // Collects handshakes for the whole packet, both after sop and after eop
  always @(negedge clk) begin
    hs_acc <= hs_acc | {hs_ack, hs_nak, hs_stall};
  end

  task automatic put(input logic [7:0] b, input logic last, input int gap);
    repeat (gap) begin
      @(posedge clk);
      link.sop <= 1'b0;
      link.vld <= 1'b0;
      link.data <= ~link.data;
    end
    @(posedge clk);
    link.sop <= 1'b0;
    link.vld <= 1'b1;
    link.data <= b;
    link.eop <= last;
  endtask

  task automatic send(input logic setup, input logic [7:0] pid, input int n,
                      input logic [7:0] base, input logic abort, input int gap,
                      output logic [2:0] hs);
    @(posedge clk);
    // Cleared on the rising edge so the negedge collector cannot undo it
    hs_acc = 3'h0;
    link.sop <= 1'b1;
    link.setup <= setup;
    put(pid, 1'b0, 0);
    for (int i = 0; i < n; i++) begin
      put(base + 8'(i), 1'b0, gap);
    end
    if (abort) begin
      @(posedge clk);
      link.vld <= 1'b0;
      link.err <= 1'b1;
    end else begin
      put(8'h5A, 1'b0, gap);
      put(8'hA5, 1'b1, gap);
    end
    @(posedge clk);
    link.vld <= 1'b0;
    link.eop <= 1'b0;
    link.err <= 1'b0;
    link.data <= ~link.data;
    repeat (4) @(negedge clk);
    hs = hs_acc;
  endtask
endmodule

// ---- tb/testbench.sv ----
// Purpose: register and packet sequences with expected values for the receive endpoint.
// Assumes: read answer within a few cycles of the strobe, handshakes within four.
// Notes: read ack latency is checked to the exact cycle; other timing is left to the design's own assertions.
`timescale 1ns/1ps
module testbench
  import urx_pkg::*;
;
  logic         clk;
  logic         nrst;
  logic         iso;
  logic         stall;
  logic         frame_lsb;
  logic         test_mode;
  urx_reg_req_t req;
  logic [15:0]  rdata;
  logic         ack;
  logic         hs_ack;
  logic         hs_nak;
  logic         hs_stall;
  logic         warn;
  urx_link_t    link;
  logic [2:0]   hs;
  logic [15:0]  v;
  logic [5:0]   lim [4];
  int           err_count;
  int           num_checks;

  urx_rx_endpoint u_dut (
    .SYS_CLK(clk), .NRST(nrst), .REG_REQ(req), .REG_RDATA(rdata), .REG_ACK(ack),
    .LINK(link), .EP_ISO(iso), .EP_STALL(stall), .FRAME_LSB(frame_lsb),
    .TEST_MODE(test_mode), .HS_ACK(hs_ack), .HS_NAK(hs_nak), .HS_STALL(hs_stall),
    .RX_WARN_FLAG(warn)
  );

  urx_host_model u_host (
    .clk(clk), .link(link), .hs_ack(hs_ack), .hs_nak(hs_nak), .hs_stall(hs_stall)
  );

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    @(posedge clk);
    req.wr <= 1'b1;
    req.addr <= a;
    req.wdata <= d;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rchk(input string nm, input logic [31:0] a, input logic [15:0] exp);
    int n;
    @(posedge clk);
    req.rd <= 1'b1;
    req.addr <= a;
    @(posedge clk);
    req.rd <= 1'b0;
    for (n = 0; n < 5 && ack !== 1'b1; n++) @(negedge clk);
    v = rdata;
    check("read ack", {15'h0, ack}, 16'h0001);
    check("read lat", 16'(n), 16'h0002);
    check(nm, v, exp);
  endtask

  task automatic pkt(input logic su, input logic [7:0] pid, input int n,
                     input logic ab, input int gap, input logic [2:0] exp);
    u_host.send(su, pid, n, 8'h10, ab, gap, hs);
    check("handshake", {13'h0, hs}, {13'h0, exp});
  endtask

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Whole run is well under two thousand cycles
  initial begin
    #200000;
    err_count++;
    final_report();
  end

  initial begin
    nrst = 1'b0;
    req = '0;
    iso = 1'b0;
    stall = 1'b0;
    frame_lsb = 1'b0;
    test_mode = 1'b0;
    lim = '{6'h00, WARN_LIM1, WARN_LIM2, WARN_LIM3};
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rchk("data rst", RXD_ADDR, REG_RST);
    rchk("stat rst", RXS_ADDR, REG_RST);
    rchk("ctrl rst", RXC_ADDR, REG_RST);
    rchk("unmapped", RXC_ADDR + 32'h2, 16'h0000);
    wr(RXC_ADDR, 16'h0001);
    pkt(1'b0, PID_DATA1, 3, 1'b0, 0, 3'b100);
    rchk("stat pkt", RXS_ADDR, 16'h0033);
    rchk("stat clr", RXS_ADDR, 16'h0003);
    rchk("en clr", RXC_ADDR, 16'h0000);
    rchk("byte0", RXD_ADDR, 16'h0010);
    rchk("cnt pop", RXS_ADDR, 16'h0002);
    rchk("byte1", RXD_ADDR, 16'h0011);
    rchk("byte2", RXD_ADDR, 16'h0012);
    rchk("empty", RXD_ADDR, 16'h0000);
    pkt(1'b0, PID_DATA1, 0, 1'b0, 0, 3'b010);
    wr(RXC_ADDR, 16'h0001);
    stall <= 1'b1;
    pkt(1'b0, PID_DATA1, 0, 1'b0, 0, 3'b001);
    @(posedge clk);
    stall <= 1'b0;
    rchk("stall en", RXC_ADDR, 16'h0000);
    pkt(1'b1, 8'hC3, 2, 1'b0, 0, 3'b100);
    rchk("stat setup", RXS_ADDR, 16'h0052);
    rchk("setup clr", RXS_ADDR, 16'h0002);
    wr(RXC_ADDR, 16'h0008);
    rchk("flushed", RXS_ADDR, 16'h0000);
    @(posedge clk);
    iso <= 1'b1;
    frame_lsb <= 1'b1;
    wr(RXC_ADDR, 16'h0001);
    u_host.send(1'b0, 8'hC3, 1, 8'h10, 1'b0, 0, hs);
    rchk("iso tog", RXS_ADDR, 16'h0021);
    pkt(1'b0, 8'hC3, 0, 1'b0, 0, 3'b000);
    @(posedge clk);
    iso <= 1'b0;
    frame_lsb <= 1'b0;
    wr(RXC_ADDR, 16'h0009);
    pkt(1'b0, PID_DATA1, 2, 1'b1, 0, 3'b000);
    rchk("errsts", RXS_ADDR, 16'h0080);
    check("err bit", v & 16'h00F0, 16'h0080);
    wr(RXC_ADDR, 16'h0008);
    rchk("err flush", RXS_ADDR, 16'h0000);
    wr(RXC_ADDR, 16'h0001);
    pkt(1'b0, 8'hC3, 16, 1'b0, 1, 3'b100);
    rchk("sat", RXS_ADDR, {12'h001, CNT_SAT});
    for (int i = 0; i < 4; i++) begin
      wr(RXC_ADDR, 16'(i) << CT_WL_LO);
      repeat (2) @(negedge clk);
      check("warn", {15'h0, warn}, {15'h0, i != 0 && FIFO_FULL - 6'h10 <= lim[i]});
    end
    for (int i = 0; i < 16; i++) begin
      rchk("drain", RXD_ADDR, 16'h0010 + 16'(i));
      if (i == 0) begin
        rchk("cnt15", RXS_ADDR, 16'h000F);
        check("warn off", {15'h0, warn}, 16'h0000);
      end
    end
    rchk("drained", RXS_ADDR, 16'h0000);
    wr(RXD_ADDR, 16'h00A5);
    rchk("no tm wr", RXD_ADDR, 16'h0000);
    @(posedge clk);
    test_mode <= 1'b1;
    wr(RXD_ADDR, 16'h00A5);
    rchk("tm wr", RXD_ADDR, 16'h00A5);
    wr(RXC_ADDR, 16'h0001);
    // Flush lands mid-packet and must wait for eop
    fork
      pkt(1'b0, PID_DATA1, 2, 1'b0, 0, 3'b100);
      begin
        repeat (2) @(posedge clk);
        wr(RXC_ADDR, 16'h0008);
      end
    join
    rchk("late flush", RXS_ADDR, 16'h0030);
    wr(RXC_ADDR, 16'h0004);
    pkt(1'b1, 8'hC3, 1, 1'b0, 0, 3'b000);
    rchk("ign setup", RXS_ADDR, 16'h0000);
    final_report();
  end
endmodule
